// ---- common/ssr_pkg.sv ----
`default_nettype none
package ssr_pkg;
	// ****************************************
	// widths and counts
	// ****************************************
	localparam int VEC_W        = 128;
	localparam int PINT_W       = 64;
	localparam int ST_W         = 80;
	localparam int CSR_W        = 32;
	localparam int LINE_W       = 128;
	localparam int WORD_W       = 32;
	localparam int HALF_W       = 16;
	localparam int FOP_W        = 11;
	localparam int FTW_W        = 8;
	localparam int IDX_W        = 5;
	localparam int REG_ADDR_W   = 8;
	localparam int NUM_LOW_VEC  = 8;
	localparam int NUM_VEC      = 16;
	localparam int NUM_PINT     = 8;
	localparam int LINE_SHIFT   = 4;
	// ****************************************
	// save image layout, one line is 16 bytes
	// ****************************************
	localparam logic [4:0] LINE_HDR0        = 5'h00;
	localparam logic [4:0] LINE_HDR1        = 5'h01;
	localparam logic [4:0] LINE_ST0         = 5'h02;
	localparam logic [4:0] LINE_VEC0        = 5'h0a;
	localparam logic [4:0] LINE_LAST_LEGACY = 5'h11;
	localparam logic [4:0] LINE_LAST_LONG   = 5'h19;
	localparam int HDR0_FCW_LSB  = 0;
	localparam int HDR0_FSW_LSB  = 16;
	localparam int HDR0_FTW_LSB  = 32;
	localparam int HDR0_FOP_LSB  = 48;
	localparam int HDR0_IP_LSB   = 64;
	localparam int HDR0_CS_LSB   = 96;
	localparam int HDR1_DP_LSB   = 0;
	localparam int HDR1_DS_LSB   = 32;
	localparam int HDR1_CSR_LSB  = 64;
	localparam int HDR1_MASK_LSB = 96;
	// ****************************************
	// control/status, flags, identification
	// ****************************************
	localparam int CSR_DAZ_BIT = 6;
	localparam int CSR_FTZ_BIT = 15;
	localparam logic [31:0] CSR_RESET        = 32'h00001f80;
	localparam logic [31:0] CSR_IMPL_DEFAULT = 32'h0000ffff;
	localparam logic [15:0] FCW_RESET        = 16'h037f;
	localparam logic [15:0] ST_EXP_ONES      = 16'hffff;
	localparam int FEATURE_DPV_BIT = 26;
	localparam logic [31:0] FLAGS_RESET      = 32'h00000002;
	localparam logic [31:0] FLAGS_CMP_MASK   = 32'h000008d5;
	localparam int FLAG_CF_BIT = 0;
	localparam int FLAG_PF_BIT = 2;
	localparam int FLAG_ZF_BIT = 6;
	// ****************************************
	// register port map (word addresses)
	// ****************************************
	localparam logic [1:0] ADDR_VEC_TOP  = 2'h0;
	localparam logic [3:0] ADDR_PINT_TOP = 4'h4;
	localparam logic [7:0] ADDR_CSR      = 8'h50;
	localparam logic [7:0] ADDR_FPCTL    = 8'h51;
	localparam logic [7:0] ADDR_FPTAG    = 8'h52;
	localparam logic [7:0] ADDR_FEATURE  = 8'h53;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h54;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h55;
	localparam logic [7:0] ADDR_STATE    = 8'h56;
	localparam logic [7:0] ADDR_FLAGS    = 8'h57;
	localparam int IRQ_W          = 3;
	localparam int IRQ_SAVE_BIT   = 0;
	localparam int IRQ_LOAD_BIT   = 1;
	localparam int IRQ_FAULT_BIT  = 2;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		MODE_REAL,
		MODE_PROT,
		MODE_V86,
		MODE_COMPAT,
		MODE_LONG64
	} ssr_mode_t;
	typedef enum logic {
		OP_SAVE,
		OP_RESTORE
	} ssr_op_t;
endpackage
`default_nettype wire

// ---- hw/ssr_operand_decode.sv ----
`default_nettype none
module ssr_operand_decode (
	input  wire ssr_pkg::ssr_mode_t mode_in,
	input  wire logic [2:0]         reg_field_in,
	input  wire logic               prefix_present_in,
	input  wire logic               prefix_reg_bit_in,
	input  wire logic               prefix_width_bit_in,
	input  wire logic               takes_gpr_in,
	output logic [3:0]              vec_index_out,
	output logic                    gpr_wide_out,
	output logic                    prefix_ignored_out
);
	import ssr_pkg::*;

	logic long_mode;
	logic prefix_live;

	// only 64-bit mode gives the prefix a meaning; other modes behave alike
	// every mode except 64-bit decodes identically
	assign long_mode = (mode_in == MODE_LONG64);
	assign prefix_live = prefix_present_in & long_mode;

	// upper eight reached only by the register-number bit
	assign vec_index_out = {prefix_live & prefix_reg_bit_in, reg_field_in};

	// width bit picks 64-bit general registers
	assign gpr_wide_out = prefix_live & prefix_width_bit_in & takes_gpr_in;

	assign prefix_ignored_out = prefix_present_in
		& ~(prefix_live & (prefix_reg_bit_in | (prefix_width_bit_in & takes_gpr_in)));
endmodule
`default_nettype wire

// ---- hw/ssr_state_save_restore.sv ----
// What this block does
// - save command takes one image operand and writes stack and vector state into it.
// - restore faults with a protection fault on an illegal saved control/status value.
// - restore with a legal control/status value loads stack and vector state.
// - identification leaf 01H feature word reports bit 26 set.
// - 128-bit registers hold two doubles or packed byte to quadword integers.
// - outside 64-bit mode eight vector registers, scalars in low quadword.
// - control/status register is 32 bits with denormal-zero and flush-zero flags.
// - eight 64-bit packed integer registers, numbered 0 to 7.
// - memory addresses come only from general registers, never vector or packed.
// - vector compares write their outcome into the 32-bit flags register.
// - usable in real, protected, virtual-8086; compatibility acts like protected.
// - 64-bit mode adds vector registers 8 to 15 via prefix bits only.
// - prefix width bit selects 64-bit general registers for such operands.
// - a prefix without meaning is ignored and the instruction runs normally.
// - no state beyond existing vector state, so save/restore covers everything.
// - outside 64-bit mode image lines of registers 8 to 15 untouched.
// - denormals-are-zero flag sits at control/status bit 6.
`default_nettype none
module ssr_state_save_restore #(
	parameter logic [31:0] CSR_IMPL_MASK = ssr_pkg::CSR_IMPL_DEFAULT,
	parameter int          MEM_ADDR_W    = 64
) (
	input  wire logic                      core_clk_in,
	input  wire logic                      rst_in,
	input  wire ssr_pkg::ssr_mode_t        mode_in,
	input  wire logic                      cmd_valid_in,
	input  wire ssr_pkg::ssr_op_t          cmd_op_in,
	input  wire logic                      cmd_width_bit_in,
	input  wire logic [MEM_ADDR_W-1:0]     cmd_gpr_base_in,
	output logic                           busy_out,
	output logic                           done_out,
	output logic                           protection_fault_out,
	output logic                           mem_req_out,
	output logic                           mem_we_out,
	output logic [MEM_ADDR_W-1:0]          mem_addr_out,
	output logic [ssr_pkg::LINE_W-1:0]     mem_wdata_out,
	input  wire logic                      mem_ack_in,
	input  wire logic [ssr_pkg::LINE_W-1:0] mem_rdata_in,
	input  wire logic [2:0]                instr_reg_field_in,
	input  wire logic                      instr_prefix_in,
	input  wire logic                      instr_prefix_reg_bit_in,
	input  wire logic                      instr_prefix_width_bit_in,
	input  wire logic                      instr_takes_gpr_in,
	output logic [3:0]                     instr_vec_index_out,
	output logic                           instr_gpr_wide_out,
	output logic                           instr_prefix_ignored_out,
	input  wire logic                      cmp_valid_in,
	input  wire logic                      cmp_zf_in,
	input  wire logic                      cmp_pf_in,
	input  wire logic                      cmp_cf_in,
	output logic [31:0]                    flags_reg_out,
	output logic [31:0]                    ctrl_status_out,
	input  wire logic [ssr_pkg::REG_ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]               reg_wdata_in,
	input  wire logic                      reg_write_in,
	input  wire logic                      reg_read_in,
	output logic [31:0]                    reg_rdata_out,
	output logic                           irq_out
);
	import ssr_pkg::*;

	// ****************************************
	// elaboration checks
	// ****************************************
	generate
		if (!CSR_IMPL_MASK[CSR_DAZ_BIT] || !CSR_IMPL_MASK[CSR_FTZ_BIT])
		begin : g_bad_mask
			$error("implemented-bit mask must hold both denormal flags");
		end
		if (MEM_ADDR_W < 16)
		begin : g_bad_addr
			$error("memory address too narrow for the save image");
		end
	endgenerate

	// ****************************************
	// architectural state
	// ****************************************
	typedef enum {
		ST_IDLE,
		ST_SAVE,
		ST_CHECK,
		ST_LOAD
	} ssr_state_t;

	// sixteen 128-bit registers shared by every packed type
	logic [VEC_W-1:0]      vector_reg [NUM_VEC];
	logic [ST_W-1:0]       stack_reg  [NUM_PINT];
	logic [CSR_W-1:0]      vector_ctrl_status_reg;
	logic [HALF_W-1:0]     fp_ctrl;
	logic [HALF_W-1:0]     fp_status;
	logic [FTW_W-1:0]      fp_tag;
	logic [FOP_W-1:0]      fp_opcode;
	logic [63:0]           fp_ip;
	logic [HALF_W-1:0]     fp_cs;
	logic [63:0]           fp_dp;
	logic [HALF_W-1:0]     fp_ds;
	logic [31:0]           flags_reg;
	logic [IRQ_W-1:0]      irq_stat;
	logic [IRQ_W-1:0]      irq_mask;
	ssr_state_t            state;
	ssr_op_t               op;
	logic                  long_op;
	logic                  wide_op;
	logic [MEM_ADDR_W-1:0] img_base;
	logic [4:0]            line;
	logic [4:0]            last_line;
	logic                  load_fire;
	logic                  csr_legal;
	logic [CSR_W-1:0]      img_csr;
	logic [3:0]            port_vec_index;
	logic                  port_is_vec;
	logic                  port_is_pint;
	logic [2:0]            port_pint_index;
	logic                  port_write_ok;
	logic [IRQ_W-1:0]      events;
	logic [IRQ_W-1:0]      next_irq_stat;
	logic [31:0]           next_rdata;
	logic [3:0]            dec_vec_index;
	logic                  dec_gpr_wide;
	logic                  dec_prefix_ignored;

	// ****************************************
	// operand decode
	// ****************************************
	ssr_operand_decode u_instr_decode (
		.mode_in             (mode_in),
		.reg_field_in        (instr_reg_field_in),
		.prefix_present_in   (instr_prefix_in),
		.prefix_reg_bit_in   (instr_prefix_reg_bit_in),
		.prefix_width_bit_in (instr_prefix_width_bit_in),
		.takes_gpr_in        (instr_takes_gpr_in),
		.vec_index_out       (dec_vec_index),
		.gpr_wide_out        (dec_gpr_wide),
		.prefix_ignored_out  (dec_prefix_ignored)
	);

	// port address bit 5 plays the register-number prefix bit
	ssr_operand_decode u_port_decode (
		.mode_in             (mode_in),
		.reg_field_in        (reg_addr_in[4:2]),
		.prefix_present_in   (reg_addr_in[5]),
		.prefix_reg_bit_in   (reg_addr_in[5]),
		.prefix_width_bit_in (1'b0),
		.takes_gpr_in        (1'b0),
		.vec_index_out       (port_vec_index),
		.gpr_wide_out        (),
		.prefix_ignored_out  ()
	);

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			instr_vec_index_out      <= 4'h0;
			instr_gpr_wide_out       <= 1'b0;
			instr_prefix_ignored_out <= 1'b0;
		end
		else
		begin
			instr_vec_index_out      <= dec_vec_index;
			instr_gpr_wide_out       <= dec_gpr_wide;
			instr_prefix_ignored_out <= dec_prefix_ignored;
		end
	end

	// ****************************************
	// image line builder
	// ****************************************
	function automatic logic [LINE_W-1:0] save_image_line(input logic [4:0] idx);
		logic [LINE_W-1:0] l;
		l = '0;
		if (idx == LINE_HDR0)
		begin
			l[HDR0_FCW_LSB +: HALF_W] = fp_ctrl;
			l[HDR0_FSW_LSB +: HALF_W] = fp_status;
			l[HDR0_FTW_LSB +: FTW_W]  = fp_tag;
			l[HDR0_FOP_LSB +: FOP_W]  = fp_opcode;
			l[HDR0_IP_LSB +: WORD_W]  = fp_ip[WORD_W-1:0];
			if (wide_op)
				l[HDR0_IP_LSB +: PINT_W] = fp_ip;
			else
				l[HDR0_CS_LSB +: HALF_W] = fp_cs;
		end
		else if (idx == LINE_HDR1)
		begin
			l[HDR1_DP_LSB +: WORD_W]  = fp_dp[WORD_W-1:0];
			if (wide_op)
				l[HDR1_DP_LSB +: PINT_W] = fp_dp;
			else
				l[HDR1_DS_LSB +: HALF_W] = fp_ds;
			l[HDR1_CSR_LSB +: CSR_W]  = vector_ctrl_status_reg;
			l[HDR1_MASK_LSB +: CSR_W] = CSR_IMPL_MASK;
		end
		else if (idx < LINE_VEC0)
			l[ST_W-1:0] = stack_reg[3'(idx - LINE_ST0)];
		else
			l = vector_reg[4'(idx - LINE_VEC0)];
		return l;
	endfunction

	function automatic logic [MEM_ADDR_W-1:0] line_addr(input logic [MEM_ADDR_W-1:0] base,
		input logic [4:0] idx);
		return base + (MEM_ADDR_W'(idx) << LINE_SHIFT);
	endfunction

	// ****************************************
	// save/restore sequencer
	// ****************************************
	// last image line depends on 64-bit mode
	assign last_line = long_op ? LINE_LAST_LONG : LINE_LAST_LEGACY;
	assign img_csr = mem_rdata_in[HDR1_CSR_LSB +: CSR_W];
	// any one in an unimplemented bit is illegal
	assign csr_legal = ((img_csr & ~CSR_IMPL_MASK) == '0);
	assign load_fire = (state == ST_LOAD) && mem_req_out && mem_ack_in;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			state                <= ST_IDLE;
			op                   <= OP_SAVE;
			long_op              <= 1'b0;
			wide_op              <= 1'b0;
			img_base             <= '0;
			line                 <= LINE_HDR0;
			busy_out             <= 1'b0;
			done_out             <= 1'b0;
			protection_fault_out <= 1'b0;
			mem_req_out          <= 1'b0;
			mem_we_out           <= 1'b0;
			mem_addr_out         <= '0;
			mem_wdata_out        <= '0;
		end
		else
		begin
			done_out             <= 1'b0;
			protection_fault_out <= 1'b0;
			unique case (state)
				ST_IDLE:
				begin
					if (cmd_valid_in)
					begin
						// image address taken from a general register only
						img_base    <= {cmd_gpr_base_in[MEM_ADDR_W-1:LINE_SHIFT],
							LINE_SHIFT'(0)};
						op          <= cmd_op_in;
						long_op     <= (mode_in == MODE_LONG64);
						// width bit has no meaning outside 64-bit mode
						wide_op     <= (mode_in == MODE_LONG64) && cmd_width_bit_in;
						busy_out    <= 1'b1;
						if (cmd_op_in == OP_SAVE)
						begin
							// save walks the single image operand
							// line 0 needs the latched width bit, so its request waits a cycle
							state        <= ST_SAVE;
							line         <= LINE_HDR0;
							mem_we_out   <= 1'b1;
							mem_addr_out <= line_addr({cmd_gpr_base_in[MEM_ADDR_W-1:LINE_SHIFT],
								LINE_SHIFT'(0)}, LINE_HDR0);
						end
						else
						begin
							// control/status line is read first, nothing written yet
							state        <= ST_CHECK;
							mem_req_out  <= 1'b1;
							line         <= LINE_HDR1;
							mem_we_out   <= 1'b0;
							mem_addr_out <= line_addr({cmd_gpr_base_in[MEM_ADDR_W-1:LINE_SHIFT],
								LINE_SHIFT'(0)}, LINE_HDR1);
						end
					end
				end
				ST_CHECK:
				begin
					if (mem_req_out && mem_ack_in)
					begin
						mem_req_out <= 1'b0;
						if (!csr_legal)
						begin
							// illegal saved value faults, state untouched
							state                <= ST_IDLE;
							busy_out             <= 1'b0;
							protection_fault_out <= 1'b1;
						end
						else
						begin
							state <= ST_LOAD;
							line  <= LINE_HDR0;
						end
					end
				end
				ST_SAVE, ST_LOAD:
				begin
					if (mem_req_out && mem_ack_in)
					begin
						mem_req_out <= 1'b0;
						if (line == last_line)
						begin
							state    <= ST_IDLE;
							busy_out <= 1'b0;
							done_out <= 1'b1;
						end
						else
							line <= line + 5'h01;
					end
					else if (!mem_req_out)
					begin
						mem_req_out  <= 1'b1;
						mem_addr_out <= line_addr(img_base, line);
						if (state == ST_SAVE)
							mem_wdata_out <= save_image_line(line);
					end
				end
			endcase
		end
	end

	// ****************************************
	// register port decode
	// ****************************************
	assign port_is_vec     = (reg_addr_in[7:6] == ADDR_VEC_TOP);
	assign port_is_pint    = (reg_addr_in[7:4] == ADDR_PINT_TOP);
	assign port_pint_index = reg_addr_in[3:1];
	// architectural state is frozen to the port while a sequence runs
	assign port_write_ok   = reg_write_in && (state == ST_IDLE);

	// ****************************************
	// vector registers
	// ****************************************
	// the whole vector state lives here and in the image
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < NUM_VEC; i++)
				vector_reg[i] <= '0;
		end
		else if (load_fire && (line >= LINE_VEC0))
			vector_reg[4'(line - LINE_VEC0)] <= mem_rdata_in;
		// scalar double sits in the low quadword word 0/1
		else if (port_write_ok && port_is_vec)
			vector_reg[port_vec_index][reg_addr_in[1:0]*WORD_W +: WORD_W] <= reg_wdata_in;
	end

	// ****************************************
	// stack / packed integer registers
	// ****************************************
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < NUM_PINT; i++)
				stack_reg[i] <= '0;
			fp_ctrl   <= FCW_RESET;
			fp_status <= '0;
			fp_tag    <= '0;
			fp_opcode <= '0;
			fp_ip     <= '0;
			fp_cs     <= '0;
			fp_dp     <= '0;
			fp_ds     <= '0;
		end
		else if (load_fire)
		begin
			if (line == LINE_HDR0)
			begin
				fp_ctrl   <= mem_rdata_in[HDR0_FCW_LSB +: HALF_W];
				fp_status <= mem_rdata_in[HDR0_FSW_LSB +: HALF_W];
				fp_tag    <= mem_rdata_in[HDR0_FTW_LSB +: FTW_W];
				fp_opcode <= mem_rdata_in[HDR0_FOP_LSB +: FOP_W];
				if (wide_op)
					fp_ip <= mem_rdata_in[HDR0_IP_LSB +: PINT_W];
				else
				begin
					fp_ip <= {32'h0, mem_rdata_in[HDR0_IP_LSB +: WORD_W]};
					fp_cs <= mem_rdata_in[HDR0_CS_LSB +: HALF_W];
				end
			end
			else if (line == LINE_HDR1)
			begin
				if (wide_op)
					fp_dp <= mem_rdata_in[HDR1_DP_LSB +: PINT_W];
				else
				begin
					fp_dp <= {32'h0, mem_rdata_in[HDR1_DP_LSB +: WORD_W]};
					fp_ds <= mem_rdata_in[HDR1_DS_LSB +: HALF_W];
				end
			end
			// legal restore loads the stack lines
			else if (line < LINE_VEC0)
				stack_reg[3'(line - LINE_ST0)] <= mem_rdata_in[ST_W-1:0];
		end
		else if (port_write_ok && port_is_pint)
		begin
			// packed integer view is the low 64 bits, exponent forced to ones
			stack_reg[port_pint_index][reg_addr_in[0]*WORD_W +: WORD_W] <= reg_wdata_in;
			stack_reg[port_pint_index][ST_W-1:PINT_W] <= ST_EXP_ONES;
		end
		else if (port_write_ok && (reg_addr_in == ADDR_FPCTL))
		begin
			fp_ctrl   <= reg_wdata_in[HALF_W-1:0];
			fp_status <= reg_wdata_in[WORD_W-1:HALF_W];
		end
		else if (port_write_ok && (reg_addr_in == ADDR_FPTAG))
		begin
			fp_tag    <= reg_wdata_in[FTW_W-1:0];
			fp_opcode <= reg_wdata_in[HALF_W +: FOP_W];
		end
	end

	// ****************************************
	// control/status and flags
	// ****************************************
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			vector_ctrl_status_reg <= CSR_RESET;
		else if (load_fire && (line == LINE_HDR1))
			vector_ctrl_status_reg <= mem_rdata_in[HDR1_CSR_LSB +: CSR_W];
		// unimplemented bits never stick; denormal flags are always implemented, so they stick
		else if (port_write_ok && (reg_addr_in == ADDR_CSR))
			vector_ctrl_status_reg <= reg_wdata_in & CSR_IMPL_MASK;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			flags_reg <= FLAGS_RESET;
		// compare outcome lands in flags, other compare flags cleared
		else if (cmp_valid_in)
		begin
			flags_reg <= flags_reg & ~FLAGS_CMP_MASK;
			flags_reg[FLAG_ZF_BIT] <= cmp_zf_in;
			flags_reg[FLAG_PF_BIT] <= cmp_pf_in;
			flags_reg[FLAG_CF_BIT] <= cmp_cf_in;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			flags_reg_out   <= FLAGS_RESET;
			ctrl_status_out <= CSR_RESET;
		end
		else
		begin
			flags_reg_out   <= flags_reg;
			// arithmetic reads the denormal flag at bit 6
			ctrl_status_out <= vector_ctrl_status_reg;
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	assign events = {protection_fault_out, done_out && (op == OP_RESTORE),
		done_out && (op == OP_SAVE)};
	// set wins over a same-cycle write-one clear
	assign next_irq_stat = (irq_stat & ~((reg_write_in && (reg_addr_in == ADDR_IRQ_STAT))
		? reg_wdata_in[IRQ_W-1:0] : '0)) | events;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			irq_stat <= '0;
			irq_mask <= '0;
			irq_out  <= 1'b0;
		end
		else
		begin
			irq_stat <= next_irq_stat;
			if (reg_write_in && (reg_addr_in == ADDR_IRQ_MASK))
				irq_mask <= reg_wdata_in[IRQ_W-1:0];
			irq_out  <= |(next_irq_stat & irq_mask);
		end
	end

	// ****************************************
	// register port read
	// ****************************************
	always_comb
	begin
		next_rdata = '0;
		if (port_is_vec)
			next_rdata = vector_reg[port_vec_index][reg_addr_in[1:0]*WORD_W +: WORD_W];
		else if (port_is_pint)
			next_rdata = stack_reg[port_pint_index][reg_addr_in[0]*WORD_W +: WORD_W];
		else if (reg_addr_in == ADDR_CSR)
			next_rdata = vector_ctrl_status_reg;
		else if (reg_addr_in == ADDR_FPCTL)
			next_rdata = {fp_status, fp_ctrl};
		else if (reg_addr_in == ADDR_FPTAG)
			next_rdata = {5'h00, fp_opcode, 8'h00, fp_tag};
		// feature word of leaf 01H reports the extension
		else if (reg_addr_in == ADDR_FEATURE)
			next_rdata[FEATURE_DPV_BIT] = 1'b1;
		else if (reg_addr_in == ADDR_IRQ_STAT)
			next_rdata[IRQ_W-1:0] = irq_stat;
		else if (reg_addr_in == ADDR_IRQ_MASK)
			next_rdata[IRQ_W-1:0] = irq_mask;
		else if (reg_addr_in == ADDR_STATE)
			next_rdata = {28'h0000000, mode_in == MODE_LONG64, op == OP_RESTORE,
				state != ST_IDLE, busy_out};
		else if (reg_addr_in == ADDR_FLAGS)
			next_rdata = flags_reg;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			reg_rdata_out <= '0;
		else if (reg_read_in)
			reg_rdata_out <= next_rdata;
		else
			reg_rdata_out <= '0;
	end
endmodule
`default_nettype wire

// ---- verification/ssr_checker.sv ----
`default_nettype none
module ssr_checker #(parameter int MEM_ADDR_W = 64) (
	input wire logic core_clk_in, rst_in, busy_out, done_out, protection_fault_out,
	input wire logic mem_req_out, mem_ack_in, cmp_valid_in, cmp_zf_in, instr_gpr_wide_out,
	input wire logic instr_takes_gpr_in, instr_prefix_in, instr_prefix_width_bit_in,
	input wire ssr_pkg::ssr_mode_t mode_in,
	input wire logic [MEM_ADDR_W-1:0] mem_addr_out,
	input wire logic [3:0] instr_vec_index_out,
	input wire logic [31:0] flags_reg_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import ssr_pkg::*;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_wait; mem_req_out && !mem_ack_in; endsequence
	a_req_held: assert property (s_wait |=> mem_req_out && $stable(mem_addr_out))
		else $error("request dropped");
	a_req_busy: assert property (mem_req_out |-> busy_out && mem_addr_out[3:0] == 4'h0)
		else $error("stray request");
	a_fault_no_load: assert property (protection_fault_out |-> !done_out ##1 !busy_out)
		else $error("fault with load");
	a_done_pulse: assert property (done_out |=> !done_out && !busy_out)
		else $error("done not a pulse");
	a_flags_zero: assert property (cmp_valid_in |-> ##2 flags_reg_out[6] == $past(cmp_zf_in, 2))
		else $error("zero flag wrong");
	a_flags_fixed: assert property (cmp_valid_in |-> ##2 flags_reg_out[1] && !flags_reg_out[7])
		else $error("fixed flags wrong");
	a_low_index: assert property (mode_in != MODE_LONG64 |=> !instr_vec_index_out[3])
		else $error("upper register reached");
	a_gpr_wide: assert property (1'b1 |=> instr_gpr_wide_out == $past(mode_in == MODE_LONG64
		&& instr_takes_gpr_in && instr_prefix_in && instr_prefix_width_bit_in)) else $error("width");
endmodule
bind ssr_state_save_restore ssr_checker #(.MEM_ADDR_W(MEM_ADDR_W)) u_chk (.*);
`default_nettype wire

// ---- verification/ssr_mem_model.sv ----
`default_nettype none
module ssr_mem_model (
	input  wire logic         clk_in, req_in, we_in,
	input  wire logic [63:0]  addr_in,
	input  wire logic [127:0] wdata_in,
	output logic              ack_out = 1'h0,
	output logic [127:0]      rdata_out = 128'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [127:0] mem [int];
	int           writes = 0, stall = 0;
	// random stalls; an idle bus shows inverted data so a stale line never looks valid
	always @(posedge clk_in)
	begin
		ack_out <= 1'h0;
		rdata_out <= ~rdata_out;
		if (req_in && !ack_out && stall > 0)
			stall <= stall - 1;
		else if (req_in && !ack_out)
		begin
			ack_out <= 1'h1;
			stall <= $urandom_range(2);
			writes <= writes + we_in;
			if (we_in)
				mem[addr_in[11:4]] = wdata_in;
			else
				rdata_out <= mem[addr_in[11:4]];
		end
	end
endmodule
`default_nettype wire

// ---- verification/ssr_state_save_restore_tb_top.sv ----
`default_nettype none
module ssr_state_save_restore_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ssr_pkg::*;
	logic core_clk_in = '0, rst_in = '1, cmd_valid_in = '0, cmd_width_bit_in = '0, mem_ack_in;
	logic instr_prefix_in = '0, instr_prefix_reg_bit_in = '0, instr_prefix_width_bit_in = '0;
	logic instr_takes_gpr_in = '0, cmp_valid_in = '0, cmp_zf_in = '0, cmp_pf_in = '0;
	logic cmp_cf_in = '0, reg_write_in = '0, reg_read_in = '0, busy_out, done_out, irq_out;
	logic protection_fault_out, mem_req_out, mem_we_out, instr_gpr_wide_out;
	logic instr_prefix_ignored_out;
	logic [2:0] instr_reg_field_in = 3'h5;
	logic [3:0] instr_vec_index_out;
	logic [7:0] reg_addr_in = 8'h0;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, flags_reg_out, ctrl_status_out, v, c;
	logic [63:0] cmd_gpr_base_in = 64'h1000, mem_addr_out;
	logic [127:0] mem_wdata_out, mem_rdata_in;
	ssr_mode_t mode_in = MODE_REAL;
	ssr_op_t cmd_op_in = OP_SAVE;
	int bad_count = 0, check_count = 0;
	ssr_state_save_restore dut (.*);
	ssr_mem_model mem (.clk_in(core_clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
		.addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .ack_out(mem_ack_in),
		.rdata_out(mem_rdata_in));
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge core_clk_in);
		{reg_addr_in, reg_wdata_in, reg_write_in, reg_read_in} <= {a, d, w, !w};
		@(posedge core_clk_in);
		{reg_write_in, reg_read_in} <= 2'h0;
		#1 v = reg_rdata_out;
	endtask
	task automatic run(ssr_op_t o, ssr_mode_t m);
		@(posedge core_clk_in);
		cmd_op_in <= o;
		mode_in <= m;
		cmd_valid_in <= '1;
		@(posedge core_clk_in);
		cmd_valid_in <= '0;
		repeat (200)
		begin
			@(posedge core_clk_in) #1;
			if (done_out || protection_fault_out)
				break;
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
		forever #50 core_clk_in = ~core_clk_in;
	initial
	begin
		#300000 bad_count++;
		summarize();
	end
	initial
	begin
		void'($urandom(85));
		c = $urandom & 32'hffbf | 32'h10040;
		repeat (6) @(posedge core_clk_in);
		rst_in <= '0;
		acc('0, 8'h53, '0);
		chk("feature", 1, v[26]);
		acc('1, 8'h55, 32'h7);
		acc('1, 8'h50, c);
		acc('0, 8'h60, '0);
		chk("unmapped", 0, v);
		chk("daz", 1, ctrl_status_out[6]);
		for (int i = 0; i < 2; i++)
		begin
			mem.writes = 0;
			run(OP_SAVE, i ? MODE_LONG64 : MODE_PROT);
			chk("lines", i ? 26 : 18, mem.writes);
			chk("image csr", c & 32'hffff, mem.mem[1][95:64]);
		end
		acc('1, 8'h50, '0);
		run(OP_RESTORE, MODE_LONG64);
		chk("done", 1, done_out);
		acc('0, 8'h50, '0);
		chk("loaded csr", c & 32'hffff, v);
		chk("irq", 1, irq_out);
		acc('1, 8'h54, 32'h7);
		acc('0, 8'h54, '0);
		chk("irq stat", 0, v);
		chk("irq clear", 0, irq_out);
		mem.mem[1][80] = 1'h1;
		run(OP_RESTORE, MODE_PROT);
		chk("fault", 1, protection_fault_out);
		acc('0, 8'h50, '0);
		chk("kept csr", c & 32'hffff, v);
		v = $urandom;
		@(posedge core_clk_in);
		{cmp_zf_in, cmp_pf_in, cmp_cf_in, cmp_valid_in} <= {v[2:0], 1'h1};
		{instr_prefix_in, instr_prefix_reg_bit_in, instr_prefix_width_bit_in} <= 3'h7;
		instr_takes_gpr_in <= '1;
		mode_in <= MODE_LONG64;
		@(posedge core_clk_in);
		cmp_valid_in <= '0;
		repeat (2) @(posedge core_clk_in);
		#1 chk("flags", {v[2], 3'h0, v[1], 1'h1, v[0]}, flags_reg_out);
		chk("wide", 32'h1d, {instr_prefix_ignored_out, instr_gpr_wide_out,
			instr_vec_index_out});
		@(posedge core_clk_in);
		mode_in <= MODE_COMPAT;
		repeat (2) @(posedge core_clk_in);
		#1 chk("compat", 32'h25, {instr_prefix_ignored_out, instr_gpr_wide_out,
			instr_vec_index_out});
		summarize();
	end
endmodule
`default_nettype wire
